//--- core/agst_bank.sv
// Target status and command registers with operation gating.
// Assumes APB from configuration software and a single core clock.
`timescale 1ns/1ps
`default_nettype none
module agst_bank (
  input  wire logic                  sys_clk_i,    // Core clock
  input  wire logic                  rst_n_i,      // Async reset, low
  input  wire agst_pkg::agst_apb_req_s apb_i,      // APB request
  output logic [31:0]                prdata_o,     // APB read data
  output logic                       pready_o,     // APB ready
  output logic                       pslverr_o,    // APB error
  input  wire agst_pkg::agst_op_s    op_i,         // Incoming AGP op
  output logic                       op_accept_o,  // Op taken into queue
  output logic                       sync_ack_o,   // Sync cycle honoured
  output logic                       agp_en_o,     // Command bit 8
  output logic                       sba_en_o,     // Command bit 9
  output logic [1:0]                 rate_o,       // Rate select 1x/2x
  output logic [5:0]                 queue_depth_o // Max outstanding - 1
);

  agst_pkg::agst_state_s st_r, st_nxt;

  // -----------------------------
  // Decode helpers
  // -----------------------------
  function automatic logic [5:0] depth_of(input logic [2:0] q);
    case (q)
      agst_pkg::AGST_Q32: depth_of = agst_pkg::AGST_DEPTH_RST;
      agst_pkg::AGST_Q16: depth_of = 6'h0F;
      agst_pkg::AGST_Q8:  depth_of = 6'h07;
      agst_pkg::AGST_Q4:  depth_of = 6'h03;
      agst_pkg::AGST_Q2:  depth_of = 6'h01;
      agst_pkg::AGST_Q1:  depth_of = 6'h00;
      default:            depth_of = agst_pkg::AGST_DEPTH_RST;
    endcase
  endfunction

  function automatic logic [31:0] status_word(input logic [2:0] q);
    status_word = '0;
    status_word[agst_pkg::AGST_DEPTH_LSB +: 6] = depth_of(q);
    status_word[agst_pkg::AGST_SBA_SUP_BIT] = 1'b1;
    status_word[1:0] = agst_pkg::AGST_RATES_SUP;
  endfunction

  logic        wr_acc;
  logic        rd_acc;
  logic        agp_en;
  logic        sba_en;
  logic [2:0]  q_wr;
  assign wr_acc = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign rd_acc = apb_i.psel & ~apb_i.penable & ~apb_i.pwrite;
  assign agp_en = st_r.command[agst_pkg::AGST_AGP_EN_BIT];
  assign sba_en = st_r.command[agst_pkg::AGST_SBA_EN_BIT];
  assign q_wr   = apb_i.pwdata[agst_pkg::AGST_CTL_Q_LSB +: 3];

  // -----------------------------
  // Next state
  // -----------------------------
  always_comb begin
    st_nxt = st_r;
    if (wr_acc) begin
      case (apb_i.paddr)
        agst_pkg::AGST_COMMAND_OFS:
          st_nxt.command = apb_i.pwdata & agst_pkg::AGST_CMD_WMASK;
        agst_pkg::AGST_CONTROL_OFS:
          if (q_wr <= agst_pkg::AGST_Q1) begin
            st_nxt.qsel = q_wr;
          end
        default: ;
      endcase
    end
    // 1x side-band command in flight survives an enable drop
    // Only a command that was actually accepted may open a 1x run
    if (op_i.valid && op_i.is_sba && ((agp_en && sba_en) || st_r.sba_busy)) begin
      st_nxt.sba_busy = ~op_i.sba_last &
                        (st_r.command[1:0] == agst_pkg::AGST_RATE_1X);
    end
    if (rd_acc) begin
      case (apb_i.paddr)
        agst_pkg::AGST_STATUS_OFS:  st_nxt.prdata = status_word(st_r.qsel);
        agst_pkg::AGST_COMMAND_OFS: st_nxt.prdata = st_r.command;
        agst_pkg::AGST_CONTROL_OFS:
          st_nxt.prdata = {19'h0, st_r.qsel, 10'h0};
        default:                    st_nxt.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.command  <= agst_pkg::AGST_COMMAND_RST;
      st_r.qsel     <= agst_pkg::AGST_Q32;
      st_r.sba_busy <= 1'b0;
      st_r.prdata   <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------
  // Operation gating
  // -----------------------------
  // Queued ops are served downstream regardless of later enable changes;
  // only acceptance into the queue and the sync acknowledge are gated here.
  always_comb begin
    op_accept_o = 1'b0;
    sync_ack_o  = 1'b0;
    if (op_i.valid) begin
      if (op_i.is_sba) begin
        op_accept_o = (agp_en & sba_en) | st_r.sba_busy;
      end else begin
        op_accept_o = agp_en;
      end
      sync_ack_o = op_i.is_sync & agp_en;
    end
  end

  assign agp_en_o      = agp_en;
  assign sba_en_o      = sba_en;
  assign rate_o        = st_r.command[1:0];
  assign queue_depth_o = depth_of(st_r.qsel);
  assign prdata_o      = st_r.prdata;
  assign pready_o      = 1'b1;
  assign pslverr_o     = 1'b0;

  // -----------------------------
  // Checks
  // -----------------------------
  status_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_acc && apb_i.paddr == agst_pkg::AGST_STATUS_OFS |=>
      prdata_o[9] && prdata_o[1:0] == 2'h3 && prdata_o[23:10] == '0)
    else $error("status fixed bits wrong");
  depth_top_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_acc && apb_i.paddr == agst_pkg::AGST_STATUS_OFS |=>
      prdata_o[31:30] == 2'h0 && prdata_o[29:24] == queue_depth_o)
    else $error("depth field wrong");
  depth_legal_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    queue_depth_o inside {6'h1F, 6'h0F, 6'h07, 6'h03, 6'h01, 6'h00})
    else $error("illegal queue depth");
  sba_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_acc && apb_i.paddr == agst_pkg::AGST_COMMAND_OFS |=>
      sba_en_o == $past(apb_i.pwdata[9]))
    else $error("side-band enable not written");
  gate_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !agp_en_o && !st_r.sba_busy |-> !op_accept_o && !sync_ack_o)
    else $error("op taken while disabled");
  pipe_on_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    agp_en_o && op_i.valid && !op_i.is_sba |-> op_accept_o)
    else $error("pipe op refused");
  sba_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    op_i.valid && op_i.is_sba && !st_r.sba_busy |->
      op_accept_o == (agp_en_o && sba_en_o))
    else $error("side-band gating wrong");
  resv_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    st_r.command[31:10] == '0 && st_r.command[7:2] == '0)
    else $error("reserved command bits set");
  sba_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    op_i.valid && op_i.is_sba && st_r.sba_busy |-> op_accept_o)
    else $error("side-band command cut short");
  busy_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !st_r.sba_busy && !(agp_en_o && sba_en_o) |=> !st_r.sba_busy)
    else $error("side-band run opened while gated");
  rate_port_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rate_o == st_r.command[1:0])
    else $error("rate port differs from command");

endmodule // agst_bank
`default_nettype wire

//--- core/agst_pkg.sv
// Constants and carrier types of the target status and command bank.
// Assumes a 200 MHz core clock and an APB register slave.
//
// Behaviour
// - Status bits 31:24 are read-only, low six bits mirror the control queue depth, top bits zero, reset 1Fh.
// - The queue depth can only be 32, 16, 8, 4, 2 or 1 requests.
// - Status bit 9 always reads one to advertise side-band addressing.
// - Status bits 1:0 always read 11b for 1x and 2x on both buses.
// - Command bit 9 is a read/write side-band enable, reset to zero.
// - With command bit 8 clear every AGP operation, sync included, is ignored, except the rest of a 1x side-band command in flight; it resets to zero.
// - Operations queued while enabled are completed after the enable is cleared.
// - A side-band command partway through delivery in 1x mode is completed if the enable falls.
// - With the enable set, requests queued over the pipe method are accepted.
// - Side-band requests are served only when both enable bits are one, or to finish a 1x side-band command in flight.
// - The chosen rate applies to both AD and side-band transfers.
package agst_pkg;

  localparam logic [7:0]  AGST_STATUS_OFS  = 8'hA4;
  localparam logic [7:0]  AGST_COMMAND_OFS = 8'hA8;
  localparam logic [7:0]  AGST_CONTROL_OFS = 8'hB0;

  localparam logic [31:0] AGST_STATUS_RST  = 32'h1F000203;
  localparam logic [31:0] AGST_COMMAND_RST = 32'h00000000;
  localparam logic [31:0] AGST_CONTROL_RST = 32'h00000000;

  localparam int          AGST_DEPTH_LSB   = 24;
  localparam int          AGST_SBA_SUP_BIT = 9;
  localparam int          AGST_SBA_EN_BIT  = 9;
  localparam int          AGST_AGP_EN_BIT  = 8;
  localparam int          AGST_CTL_Q_LSB   = 10;

  localparam logic [5:0]  AGST_DEPTH_RST   = 6'h1F;
  localparam logic [1:0]  AGST_RATES_SUP   = 2'h3;
  localparam logic [1:0]  AGST_RATE_1X     = 2'h1;
  localparam logic [1:0]  AGST_RATE_2X     = 2'h2;
  localparam logic [31:0] AGST_CMD_WMASK   = 32'h00000303;
  localparam logic [31:0] AGST_CTL_WMASK   = 32'h00001C00;

  // Queue depth select codes
  typedef enum logic [2:0] {
    AGST_Q32 = 3'h0,
    AGST_Q16 = 3'h1,
    AGST_Q8  = 3'h2,
    AGST_Q4  = 3'h3,
    AGST_Q2  = 3'h4,
    AGST_Q1  = 3'h5
  } agst_qsel_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } agst_apb_req_s;

  typedef struct packed {
    logic        valid;
    logic        is_sba;
    logic        is_sync;
    logic        sba_last;
  } agst_op_s;

  typedef struct packed {
    logic [31:0] command;
    logic [2:0]  qsel;
    logic        sba_busy;
    logic [31:0] prdata;
  } agst_state_s;

endpackage

//--- testbench/agp_target_status_command_tb.sv
// Self-checking bench of the target status and command bank.
// Assumes the graphics master model drives the op port.
`timescale 1ns/1ps
`default_nettype none
module agp_target_status_command_tb;
  logic                    sys_clk_i;
  logic                    rst_n_i;
  agst_pkg::agst_apb_req_s apb;
  agst_pkg::agst_op_s      op;
  logic [31:0]             prdata, q;
  logic                    pready, acc, sack, agp_en, sba_en;
  logic [1:0]              rate;
  logic [5:0]              depth;
  int                      fails, samples_checked, n_acc, n_sync;
  localparam logic [7:0]   ST = agst_pkg::AGST_STATUS_OFS;
  localparam logic [7:0]   CM = agst_pkg::AGST_COMMAND_OFS;
  agst_bank DUT (.sys_clk_i, .rst_n_i, .apb_i(apb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(), .op_i(op), .op_accept_o(acc),
    .sync_ack_o(sack), .agp_en_o(agp_en), .sba_en_o(sba_en),
    .rate_o(rate), .queue_depth_o(depth));
  agst_gfx_master gm (.sys_clk_i, .op_o(op));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (acc === 1'b1) n_acc <= n_acc + 1;
    if (sack === 1'b1) n_sync <= n_sync + 1;
  end
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk_i);
    apb.penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    q = prdata;
    apb <= '0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(input logic sba, sync, drop, input int beats, ea, es);
    @(negedge sys_clk_i);
    n_acc = 0;
    n_sync = 0;
    fork
      gm.issue(sba, sync, beats);
      if (drop) begin
        repeat (2) @(posedge sys_clk_i);
        rw(1'b1, CM, 32'h00000201);
      end
    join
    @(negedge sys_clk_i);
    chk("accepted", ea, n_acc);
    chk("sync acks", es, n_sync);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    fails++;
    print_verdict;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    apb = '0;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rw(0, ST, 0); chk("status", 32'h1F000203, q);
    rw(0, CM, 0); chk("command", 32'h0, q);
    run(0, 1, 0, 1, 0, 0);
    run(0, 0, 0, 2, 0, 0);
    rw(1, ST, 0); rw(0, ST, 0); chk("status ro", 32'h1F000203, q);
    rw(1, 8'hC0, 32'hFFFFFFFF); rw(0, 8'hC0, 0); chk("unmapped", 0, q);
    $display("test reset and gating done");
    rw(1, CM, 32'hFFFFFCFD); rw(0, CM, 0); chk("reserved", 32'h1, q);
    rw(1, CM, 32'h00000101);
    run(0, 0, 0, 3, 3, 0);
    run(0, 1, 0, 1, 1, 1);
    run(1, 0, 0, 1, 0, 0);
    rw(1, CM, 32'h00000301);
    @(negedge sys_clk_i);
    chk("enables", 32'h3, {30'h0, sba_en, agp_en});
    run(1, 0, 0, 2, 2, 0);
    run(1, 0, 1, 6, 6, 0);
    run(1, 0, 0, 1, 0, 0);
    $display("test op gating done");
    for (int c = 0; c < 6; c++) begin
      rw(1, agst_pkg::AGST_CONTROL_OFS, 32'(c) << 10);
      rw(0, ST, 0);
      chk("depth", {2'h0, 6'((32 >> c) - 1), 24'h000203}, q);
    end
    rw(1, agst_pkg::AGST_CONTROL_OFS, 32'h00001800);
    chk("depth port", 32'h0, {26'h0, depth});
    rw(1, CM, 32'h00000302);
    @(negedge sys_clk_i);
    chk("rate", 32'h2, {30'h0, rate});
    $display("test depth and rate done");
    print_verdict;
  end
endmodule // agp_target_status_command_tb
`default_nettype wire

//--- testbench/agst_gfx_master.sv
// Graphics master model: issues pipe, side-band and sync ops.
// Assumes the bank samples its op port on the rising core clock.
`timescale 1ns/1ps
`default_nettype none
module agst_gfx_master (
  input  wire logic              sys_clk_i, // Core clock
  output var agst_pkg::agst_op_s op_o       // Op to the target
);
  initial op_o = '0;
  // One beat a cycle, last beat of a command flagged
  task automatic issue(input logic sba, input logic sync, input int beats);
    for (int i = 0; i < beats; i++) begin
      @(posedge sys_clk_i);
      op_o <= '{1'b1, sba, sync, i == beats - 1};
    end
    @(posedge sys_clk_i);
    op_o <= '0;
  endtask
endmodule // agst_gfx_master
`default_nettype wire
